// ### core/gfvc_top.sv
// gfvc_top: gated frequency / voltage measurement counter with its instrument bus front end
// assumes a software master on the plain register port, and that the reference clock,
// the selected input signal and the stop-count pulse arrive asynchronously on pins
//
// Operation
// - frequency mode opens voltmeter switch and routes frequency gate into clock counter
// - armed selector closes frequency and cycle gates on next input cycle start
// - while gates are closed, carries of both counters go to the controller
// - disarmed selector opens both gates at next input cycle start
// - readout begins by presenting cycle counter stage one in parallel
// - each shift moves next stages into stage one until all stages read
// - voltage mode routes the voltmeter gate into the clock counter
// - first reference pulse after arming closes gate; then count every reference pulse
// - stop-count pulse opens stop-count gate and ends accumulation
// - stop-count gate stays open after a voltage measurement until the next voltmeter arm
// - voltage mode leaves cycle counter idle; same stage readout used
// - four-bit enable code: three bits pick one of eight lines, fourth enables
// - each listener holds one data code for each of sixteen select codes
// - select codes decode only while own enable line is asserted
// - data codes latch only when triggered by decoded select line
// - select bits leave controller low-true, inverted onto bus; data buffered
// - decoded line n asserts low when enable bits equal n
// - unbuffered return lines carry status or counts back to controller
// - cycle counter: two stages, combined ratio 32
// - clock counter: three stages, combined ratio 2048
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module gfvc_top
  import gfvc_pkg::*;
#(
  parameter logic [2:0] COUNTER_UNIT = 3'd5   // enable line the counter listens on
)(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // measurement pins
  input  wire logic        ref_clk_i,                // 2 MHz reference
  input  wire logic        selected_count_input_i,   // signal under frequency test
  input  wire logic        stop_count_i,             // end pulse from the converter
  output logic             ramp_start_o,
  output logic             volt_switch_closed_o,
  output logic             clk_gate_from_volt_o,
  output logic             freq_gate_closed_o,
  output logic             cycle_gate_closed_o,
  output logic             stop_gate_open_o,
  output logic             carry_clk_o,
  output logic             carry_cyc_o,
  // instrument bus
  output logic      [3:0]  unit_enable_code_o,
  output logic      [7:0]  decoded_unit_lines_n_o,
  output logic      [3:0]  function_select_code_o,
  output logic      [3:0]  function_value_code_o,
  output logic             bus_strobe_o,
  output logic      [3:0]  return_data_o,
  output logic             return_data_oe_o
);

  // ---------------- synchronisers ----------------
  // three flops per pin; logic reads only the second and third stages
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {stop_count_i, selected_count_input_i, ref_clk_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // rising edges, taken between the second and a third flop
  wire ref_tick_w  = sync2_q[0] & ~sync3_q[0];
  wire sig_edge_w  = sync2_q[1] & ~sync3_q[1];
  wire stop_edge_w = sync2_q[2] & ~sync3_q[2];

  // ---------------- register port decode ----------------
  wire wr_bus_w = reg_wr_i && (reg_addr_i == GFVC_OFF_BUS_CMD);

  // bus command word: one write issues one bus cycle
  logic [15:0] bus_q;
  logic        bus_stb_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_q     <= GFVC_BUS_RESET;
      bus_stb_q <= 1'b0;
    end
    else
    begin
      if (wr_bus_w)
        bus_q <= reg_wdata_i[15:0];
      bus_stb_q <= wr_bus_w;
    end
  end

  // ---------------- instrument bus ----------------
  // enable code sits on controller lines 10..13
  wire [3:0] ena_code_w = bus_q[GFVC_ENA_LSB +: 4];
  // controller drives select low-true on lines 00..03
  wire [3:0] port_sel_low_w = ~bus_q[GFVC_SEL_LSB +: 4];
  wire [3:0] dat_code_w     = bus_q[GFVC_DAT_LSB +: 4];

  // decoder: line n low when enable bits equal n and gate bit low
  logic [7:0] unit_lines_n_w;
  genvar gu;
  generate
    for (gu = 0; gu < 8; gu++)
    begin : g_unit
      assign unit_lines_n_w[gu] = ~(~ena_code_w[GFVC_ENA_GATE_BIT]
                                   && (ena_code_w[2:0] == 3'(gu)));
    end
  endgenerate

  // inverting select buffers restore high-true on the bus
  wire [3:0] bus_sel_w = ~port_sel_low_w;

  // listener: select decoded only under own enable line
  wire        unit_on_w = ~unit_lines_n_w[COUNTER_UNIT];
  wire [15:0] sel_hit_w = (bus_stb_q && unit_on_w) ? (16'h0001 << bus_sel_w) : 16'h0000;

  // one data latch per select code, clocked by its decoded line
  logic [3:0] code_latch_q [16];
  genvar gs;
  generate
    for (gs = 0; gs < 16; gs++)
    begin : g_latch
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          code_latch_q[gs] <= 4'h0;
        else if (sel_hit_w[gs])
          code_latch_q[gs] <= dat_code_w;
      end
    end
  endgenerate

  // clock counter source: 0 frequency gate, 1 voltmeter gate
  wire volt_src_w = code_latch_q[GFVC_SEL_CONFIG][0];

  // action strobes, one cycle each
  wire act_w       = sel_hit_w[GFVC_SEL_ACTION];
  wire clr_arm_w   = act_w && dat_code_w[GFVC_ACT_CLR_ARM];
  wire disarm_w    = act_w && dat_code_w[GFVC_ACT_DISARM];
  wire volt_arm_w  = act_w && dat_code_w[GFVC_ACT_VOLT_ARM];
  wire shift_w     = act_w && dat_code_w[GFVC_ACT_SHIFT];
  wire rdback_w    = sel_hit_w[GFVC_SEL_RDBACK];

  // ---------------- mode sequencer ----------------
  gfvc_state_t state_q;
  gfvc_state_t state_d;
  logic        disarm_q;   // disarm request pending until next input edge

  // next-state logic; clear-and-arm takes effect only in frequency mode
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      GFVC_IDLE, GFVC_DONE:
      begin
        if (clr_arm_w && !volt_src_w)
          state_d = GFVC_F_ARM;
        else if (volt_arm_w && volt_src_w)
          state_d = GFVC_V_ARM;
      end
      GFVC_F_ARM:
        if (sig_edge_w)
          state_d = GFVC_F_RUN;
      GFVC_F_RUN:
        if (sig_edge_w && disarm_q)
          state_d = GFVC_DONE;
      GFVC_V_ARM:
        if (ref_tick_w)
          state_d = GFVC_V_RUN;
      GFVC_V_RUN:
        if (stop_edge_w)
          state_d = GFVC_DONE;
      default:
        state_d = GFVC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= GFVC_IDLE;
    else
      state_q <= state_d;
  end

  // disarm is remembered so that the gates open only on a whole-cycle boundary
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      disarm_q <= 1'b0;
    else if (state_q != GFVC_F_RUN)
      disarm_q <= 1'b0;
    else if (disarm_w)
      disarm_q <= 1'b1;
  end

  // gate conditions
  wire f_run_w   = (state_q == GFVC_F_RUN);
  wire v_run_w   = (state_q == GFVC_V_RUN);
  // cycle counter only runs in frequency mode
  wire cyc_inc_w = f_run_w && sig_edge_w;
  // clock counter counts reference pulses through whichever gate is routed
  wire clk_inc_w = ref_tick_w && ((f_run_w && !volt_src_w) || (v_run_w && volt_src_w));

  // ---------------- counter stages ----------------
  // readout chain order: cyc1 <- cyc2 <- clk3 <- clk2 <- clk1
  logic [3:0] cyc1_q;
  logic [3:0] cyc2_q;
  logic [3:0] clk1_q;
  logic [3:0] clk2_q;
  logic [3:0] clk3_q;

  // stage rollovers form the carry chains
  wire cyc1_wrap_w = cyc_inc_w && (cyc1_q == GFVC_CYC1_LAST);
  wire cyc_carry_w = cyc1_wrap_w && (cyc2_q == GFVC_CYC2_LAST);
  wire clk1_wrap_w = clk_inc_w && (clk1_q == GFVC_CLK1_LAST);
  wire clk2_wrap_w = clk1_wrap_w && (clk2_q == GFVC_CLK2_LAST);
  wire clk_carry_w = clk2_wrap_w && (clk3_q == GFVC_CLK3_LAST);

  // a shift reloads stages; clear-and-arm or voltmeter arm wipes them; counting otherwise
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cyc1_q <= 4'h0;
      cyc2_q <= 4'h0;
      clk1_q <= 4'h0;
      clk2_q <= 4'h0;
      clk3_q <= 4'h0;
    end
    else if (clr_arm_w || volt_arm_w)
    begin
      cyc1_q <= 4'h0;
      cyc2_q <= 4'h0;
      clk1_q <= 4'h0;
      clk2_q <= 4'h0;
      clk3_q <= 4'h0;
    end
    else if (shift_w)
    begin
      cyc1_q <= cyc2_q;
      cyc2_q <= clk3_q;
      clk3_q <= clk2_q;
      clk2_q <= clk1_q;
      clk1_q <= 4'h0;
    end
    else
    begin
      if (cyc_inc_w)
        cyc1_q <= cyc1_wrap_w ? 4'h0 : cyc1_q + 4'h1;
      if (cyc1_wrap_w)
        cyc2_q <= (cyc2_q == GFVC_CYC2_LAST) ? 4'h0 : cyc2_q + 4'h1;
      if (clk_inc_w)
        clk1_q <= clk1_wrap_w ? 4'h0 : clk1_q + 4'h1;
      if (clk1_wrap_w)
        clk2_q <= (clk2_q == GFVC_CLK2_LAST) ? 4'h0 : clk2_q + 4'h1;
      if (clk2_wrap_w)
        clk3_q <= (clk3_q == GFVC_CLK3_LAST) ? 4'h0 : clk3_q + 4'h1;
    end
  end

  // ---------------- carries and tallies ----------------
  // carries leave one cycle after their counting tick, so up to one cycle after the gates open; tallies let software count them
  logic        carry_clk_q;
  logic        carry_cyc_q;
  logic [15:0] tally_clk_q;
  logic [15:0] tally_cyc_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      carry_clk_q <= 1'b0;
      carry_cyc_q <= 1'b0;
      tally_clk_q <= 16'h0000;
      tally_cyc_q <= 16'h0000;
    end
    else
    begin
      carry_clk_q <= clk_carry_w;
      carry_cyc_q <= cyc_carry_w;
      if (clr_arm_w || volt_arm_w)
      begin
        tally_clk_q <= 16'h0000;
        tally_cyc_q <= 16'h0000;
      end
      else
      begin
        if (clk_carry_w)
          tally_clk_q <= tally_clk_q + 16'h0001;
        if (cyc_carry_w)
          tally_cyc_q <= tally_cyc_q + 16'h0001;
      end
    end
  end

  // ---------------- pin outputs and return lines ----------------
  // ramp start pulse, stop gate, and return-line drive all registered
  logic       ramp_q;
  logic       stop_open_q;
  logic [3:0] ret_q;
  logic       ret_oe_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ramp_q      <= 1'b0;
      stop_open_q <= 1'b0;
      ret_q       <= 4'h0;
      ret_oe_q    <= 1'b0;
    end
    else
    begin
      ramp_q <= volt_arm_w && volt_src_w && (state_q == GFVC_IDLE || state_q == GFVC_DONE);
      // stop gate opens on the converter pulse and recloses on the next voltmeter arm
      if (v_run_w && stop_edge_w)
        stop_open_q <= 1'b1;
      else if (state_d == GFVC_V_ARM)
        stop_open_q <= 1'b0;
      // stage one goes back on the unbuffered lines for one bus cycle
      ret_oe_q <= rdback_w;
      if (rdback_w)
        ret_q <= cyc1_q;
    end
  end

  // ---------------- register reads ----------------
  wire [31:0] status_w = {20'h0_0000, stop_open_q, disarm_q, volt_src_w, 3'h0, state_q};
  wire [31:0] rd_mux_w = (reg_addr_i == GFVC_OFF_BUS_CMD)  ? {16'h0000, bus_q} :
                         (reg_addr_i == GFVC_OFF_STATUS)   ? status_w :
                         (reg_addr_i == GFVC_OFF_CARRIES)  ? {tally_cyc_q, tally_clk_q} :
                         (reg_addr_i == GFVC_OFF_READBACK) ? {28'h000_0000, cyc1_q} :
                                                             32'h0000_0000;

  // read data stands only in the cycle after the strobe; unmapped reads return zero
  logic [31:0] rdata_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= reg_rd_i ? rd_mux_w : 32'h0000_0000;
  end

  // ---------------- output assignments ----------------
  assign reg_rdata_o            = rdata_q;
  assign ramp_start_o           = ramp_q;
  assign volt_switch_closed_o   = volt_src_w && (state_q == GFVC_V_RUN);   // open in frequency mode
  assign clk_gate_from_volt_o   = volt_src_w;
  assign freq_gate_closed_o     = f_run_w;
  assign cycle_gate_closed_o    = f_run_w;
  assign stop_gate_open_o       = stop_open_q;
  assign carry_clk_o            = carry_clk_q;
  assign carry_cyc_o            = carry_cyc_q;
  assign unit_enable_code_o     = ena_code_w;
  assign decoded_unit_lines_n_o = unit_lines_n_w;
  assign function_select_code_o = bus_sel_w;
  assign function_value_code_o  = dat_code_w;
  assign bus_strobe_o           = bus_stb_q;
  assign return_data_o          = ret_q;
  assign return_data_oe_o       = ret_oe_q;

endmodule // gfvc_top

`default_nettype wire

// ### core/gfvc_pkg.sv
// gfvc_pkg: shared constants for the gated frequency / voltage counter
// assumes one 100 MHz system clock; all offsets are byte addresses of 32-bit words
package gfvc_pkg;

  // register map (byte offsets)
  localparam logic [3:0] GFVC_OFF_BUS_CMD  = 4'h0;  // instrument bus cycle issue
  localparam logic [3:0] GFVC_OFF_STATUS   = 4'h4;  // gate and sequencer state
  localparam logic [3:0] GFVC_OFF_CARRIES  = 4'h8;  // carry tallies
  localparam logic [3:0] GFVC_OFF_READBACK = 4'hC;  // presented stage value

  // bus command word field positions
  localparam int GFVC_ENA_LSB = 0;
  localparam int GFVC_SEL_LSB = 4;
  localparam int GFVC_DAT_LSB = 8;

  // enable code: bit 3 low lets the decoder run, bits 2..0 pick the line
  localparam int GFVC_ENA_GATE_BIT = 3;

  // select codes understood by the counter listener
  localparam logic [3:0] GFVC_SEL_CONFIG = 4'h0;  // data bit 0: clock gate source
  localparam logic [3:0] GFVC_SEL_ACTION = 4'h1;  // one-shot actions
  localparam logic [3:0] GFVC_SEL_RDBACK = 4'h2;  // drive stage value onto return lines

  // action data bits
  localparam int GFVC_ACT_CLR_ARM  = 0;  // clear both counters and arm frequency gate
  localparam int GFVC_ACT_DISARM   = 1;  // disarm frequency gate
  localparam int GFVC_ACT_VOLT_ARM = 2;  // arm voltmeter gate and fire ramp start
  localparam int GFVC_ACT_SHIFT    = 3;  // shift next stage into presented stage

  // stage moduli: cycle counter 16 x 2 = 32, clock counter 16 x 16 x 8 = 2048
  localparam logic [3:0] GFVC_CYC1_LAST = 4'hF;
  localparam logic [3:0] GFVC_CYC2_LAST = 4'h1;
  localparam logic [3:0] GFVC_CLK1_LAST = 4'hF;
  localparam logic [3:0] GFVC_CLK2_LAST = 4'hF;
  localparam logic [3:0] GFVC_CLK3_LAST = 4'h7;

  // reset values
  localparam logic [15:0] GFVC_BUS_RESET = 16'h0008;  // enable code decoder off

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    GFVC_IDLE   = 6'b00_0001,
    GFVC_F_ARM  = 6'b00_0010,
    GFVC_F_RUN  = 6'b00_0100,
    GFVC_V_ARM  = 6'b00_1000,
    GFVC_V_RUN  = 6'b01_0000,
    GFVC_DONE   = 6'b10_0000
  } gfvc_state_t;

endpackage

// ### bench/gfvc_chk.sv
// gfvc_chk: port-level assertions for the gated counter and its bus listener
// assumes it is bound to gfvc_top and sees nothing but that module's ports
`timescale 1ns/10ps
`default_nettype none

module gfvc_chk
  import gfvc_pkg::*;
#(
  parameter logic [2:0] COUNTER_UNIT = 3'd5
)(
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic       ramp_start_o,
  input wire logic       volt_switch_closed_o,
  input wire logic       clk_gate_from_volt_o,
  input wire logic       freq_gate_closed_o,
  input wire logic       cycle_gate_closed_o,
  input wire logic       stop_gate_open_o,
  input wire logic       carry_clk_o,
  input wire logic       carry_cyc_o,
  input wire logic [3:0] unit_enable_code_o,
  input wire logic [7:0] decoded_unit_lines_n_o,
  input wire logic [3:0] function_select_code_o,
  input wire logic [3:0] function_value_code_o,
  input wire logic       bus_strobe_o,
  input wire logic       return_data_oe_o
);
  // own enable line, and whether any count window is open
  wire logic own_line_n = decoded_unit_lines_n_o[COUNTER_UNIT];
  wire logic counting   = freq_gate_closed_o | volt_switch_closed_o;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // decoder pulls exactly the addressed line low, none while switched off
  chk_enable_decode: assert property (
    decoded_unit_lines_n_o == (unit_enable_code_o[3] ? 8'hFF : ~(8'h01 << unit_enable_code_o[2:0])))
    else $error("enable lines do not match enable code");
  chk_codes_stand: assert property (!bus_strobe_o |->
    $stable(function_select_code_o) && $stable(function_value_code_o))
    else $error("bus codes changed without a bus cycle");
  chk_readback_drive: assert property (
    bus_strobe_o && !own_line_n && function_select_code_o == GFVC_SEL_RDBACK |=> return_data_oe_o)
    else $error("readback cycle did not drive return lines");
  chk_readback_cause: assert property (
    return_data_oe_o |-> $past(bus_strobe_o) && !$past(own_line_n))
    else $error("return lines driven without own enable line");
  chk_gates_paired: assert property (freq_gate_closed_o == cycle_gate_closed_o)
    else $error("frequency and cycle gates disagree");
  chk_freq_route: assert property (
    freq_gate_closed_o |-> !volt_switch_closed_o && !clk_gate_from_volt_o)
    else $error("voltmeter path active during frequency count");
  chk_volt_route: assert property (
    volt_switch_closed_o |-> clk_gate_from_volt_o && !cycle_gate_closed_o)
    else $error("voltage count with wrong routing");
  chk_arm_to_count: assert property (ramp_start_o |-> ##[1:70] volt_switch_closed_o)
    else $error("voltmeter gate did not close after arming");
  chk_stop_opens: assert property ($fell(volt_switch_closed_o) |-> ##[0:1] stop_gate_open_o)
    else $error("stop gate not open after voltage count");
  chk_stop_reclosed: assert property (ramp_start_o |-> ##[0:1] !stop_gate_open_o)
    else $error("stop gate still open at new voltage arm");
  chk_carry_clock: assert property (
    carry_clk_o |-> counting || $past(counting) || $past(counting, 2))
    else $error("clock carry outside a count window");
  chk_carry_cycle: assert property (
    carry_cyc_o |-> cycle_gate_closed_o || $past(cycle_gate_closed_o) || $past(cycle_gate_closed_o, 2))
    else $error("cycle carry outside a frequency window");
endmodule // gfvc_chk

bind gfvc_top gfvc_chk #(.COUNTER_UNIT(COUNTER_UNIT)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ramp_start_o(ramp_start_o),
  .volt_switch_closed_o(volt_switch_closed_o), .clk_gate_from_volt_o(clk_gate_from_volt_o),
  .freq_gate_closed_o(freq_gate_closed_o), .cycle_gate_closed_o(cycle_gate_closed_o),
  .stop_gate_open_o(stop_gate_open_o), .carry_clk_o(carry_clk_o), .carry_cyc_o(carry_cyc_o),
  .unit_enable_code_o(unit_enable_code_o), .decoded_unit_lines_n_o(decoded_unit_lines_n_o),
  .function_select_code_o(function_select_code_o), .function_value_code_o(function_value_code_o),
  .bus_strobe_o(bus_strobe_o), .return_data_oe_o(return_data_oe_o)
);
`default_nettype wire

// ### bench/gfvc_sig_src.sv
// gfvc_sig_src: behavioural far side: reference clock, signal under test, converter stop pulse
// assumes the bench scales the reference period down so a clock carry fits in a short run
`timescale 1ns/10ps
`default_nettype none

module gfvc_sig_src
#(
  parameter int REF_HALF_NS = 40
)(
  input  wire logic        ramp_start_i,
  input  wire logic        sig_run_i,
  input  wire logic [7:0]  sig_half_i,
  input  wire logic [15:0] stop_ticks_i,
  output var  logic        ref_clk_o,
  output var  logic        sig_o,
  output var  logic        stop_o
);
  // free-running time base, faster than the real one to keep runs short
  initial
  begin
    ref_clk_o = 1'b0;
    forever #(REF_HALF_NS) ref_clk_o = ~ref_clk_o;
  end

  // signal under test: whole cycles only, parks low when halted
  initial
  begin
    sig_o = 1'b0;
    forever
    begin
      wait (sig_run_i);
      sig_o = 1'b1;
      #(int'(sig_half_i) * 10);
      sig_o = 1'b0;
      #(int'(sig_half_i) * 10);
    end
  end

  // converter: stop pulse a set number of reference ticks after the ramp starts
  initial
  begin
    stop_o = 1'b0;
    forever
    begin
      @(posedge ramp_start_i);
      repeat (stop_ticks_i) @(posedge ref_clk_o);
      stop_o = 1'b1;
      #100;
      stop_o = 1'b0;
    end
  end
endmodule // gfvc_sig_src
`default_nettype wire

// ### bench/gfvc_top_bench.sv
// gfvc_top_bench: self-checking bench for the gated frequency / voltage counter
// assumes the source model on the pins and the checker bound into the design
`timescale 1ns/10ps
`default_nettype none

module gfvc_top_bench
  import gfvc_pkg::*;
;
  logic             clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i, sig_run;
  logic [3:0]       reg_addr_i, rs, rd_v;
  logic [31:0]      reg_wdata_i, n_ref, n_sig, n_cc, n_yc, r;
  logic [7:0]       sig_half;
  logic [15:0]      stop_ticks;
  wire logic [31:0] reg_rdata_o;
  wire logic        ref_clk, sig, stop, ramp_start_o, volt_switch_closed_o, clk_gate_from_volt_o;
  wire logic        freq_gate_closed_o, cycle_gate_closed_o, stop_gate_open_o, carry_clk_o, carry_cyc_o;
  wire logic        bus_strobe_o, return_data_oe_o;
  wire logic [3:0]  unit_enable_code_o, function_select_code_o, function_value_code_o, return_data_o;
  wire logic [7:0]  decoded_unit_lines_n_o;
  int               bad_count, num_checks, cyc_cnt, e, v;

  gfvc_top dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ref_clk_i(ref_clk),
    .selected_count_input_i(sig), .stop_count_i(stop), .ramp_start_o(ramp_start_o),
    .volt_switch_closed_o(volt_switch_closed_o), .clk_gate_from_volt_o(clk_gate_from_volt_o),
    .freq_gate_closed_o(freq_gate_closed_o), .cycle_gate_closed_o(cycle_gate_closed_o),
    .stop_gate_open_o(stop_gate_open_o), .carry_clk_o(carry_clk_o), .carry_cyc_o(carry_cyc_o),
    .unit_enable_code_o(unit_enable_code_o), .decoded_unit_lines_n_o(decoded_unit_lines_n_o),
    .function_select_code_o(function_select_code_o), .function_value_code_o(function_value_code_o),
    .bus_strobe_o(bus_strobe_o), .return_data_o(return_data_o), .return_data_oe_o(return_data_oe_o));

  gfvc_sig_src #(.REF_HALF_NS(40)) src (
    .ramp_start_i(ramp_start_o), .sig_run_i(sig_run), .sig_half_i(sig_half), .stop_ticks_i(stop_ticks),
    .ref_clk_o(ref_clk), .sig_o(sig), .stop_o(stop));

  // 100 MHz system clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // independent tallies of edges while a window is open, and of carries at any time
  always @(posedge ref_clk) if ((freq_gate_closed_o | volt_switch_closed_o) === 1'b1) n_ref += 1;
  always @(posedge sig) if (freq_gate_closed_o === 1'b1) n_sig += 1;
  always @(posedge clk_sys_i) if (carry_clk_o === 1'b1) n_cc += 1;
  always @(posedge clk_sys_i) if (carry_cyc_o === 1'b1) n_yc += 1;

  // hang guard: longest path is the frequency run of about 17000 cycles
  always @(posedge clk_sys_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 60000)
    begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [7:0] exp_lines(input logic [3:0] code);
    return code[3] ? 8'hFF : ~(8'h01 << code[2:0]);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // async pin edges may land either side of a gate change, so allow a small slack
  task automatic check_near(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    num_checks++;
    if ($isunknown(got) || (got > exp ? got - exp : exp - got) > tol)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // one instrument bus cycle; returns once the listener has taken it
  task automatic bus(input logic [3:0] en, input logic [3:0] sel, input logic [3:0] dat);
    wr(GFVC_OFF_BUS_CMD, {20'h0_0000, dat, sel, en});
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic stage(output logic [3:0] val);
    logic [31:0] rb;
    bus(4'h5, GFVC_SEL_RDBACK, 4'h0);
    check({31'h0, return_data_oe_o}, 32'h0000_0001);
    val = return_data_o;
    rd(GFVC_OFF_READBACK, rb);
    check(rb, {28'h0, val});
    bus(4'h5, GFVC_SEL_ACTION, 4'h8);
  endtask

  // reads tallies and all stages, rebuilds the clock total (and the cycle total outside voltage mode), compares with edge tallies
  task automatic readout(input bit volt);
    logic [31:0] car;
    logic [3:0]  s [6];
    int          k;
    rd(GFVC_OFF_CARRIES, car);
    check({16'h0, car[15:0]}, n_cc);
    check({16'h0, car[31:16]}, n_yc);
    for (k = 0; k < 6; k++) stage(s[k]);
    check({28'h0, s[5]}, 32'h0000_0000);
    check({28'h0, s[1] & 4'hE}, 32'h0000_0000);
    check({28'h0, s[2] & 4'h8}, 32'h0000_0000);
    if (!volt) check_near({11'h0, car[31:16], 5'h00} + {27'h0, s[1][0], s[0]}, n_sig, 1);
    check_near({5'h0, car[15:0], 11'h0} + {21'h0, s[2][2:0], s[3], s[4]}, n_ref, 2);
  endtask

  task automatic wait_on(input bit volt, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && (volt ? volt_switch_closed_o : freq_gate_closed_o) !== lvl; i++)
      @(posedge clk_sys_i) #1;
    #1;
    check({31'h0, volt ? volt_switch_closed_o : freq_gate_closed_o}, {31'h0, lvl});
  endtask

  task automatic test_done();
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence: decode sweep, refusals, one frequency count, two voltage counts
  initial
  begin
    r = $urandom(32'h18cc);
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, sig_run, rst_b_i} = '0;
    {n_ref, n_sig, n_cc, n_yc, stop_ticks} = '0;
    sig_half = 8'h0A;
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    #1;
    check({24'h0, decoded_unit_lines_n_o}, 32'h0000_00FF);
    for (e = 0; e < 16; e++)
    begin
      rs   = 4'(3 + $urandom % 13);
      rd_v = 4'($urandom);
      bus(4'(e), rs, rd_v);
      check({20'h0, function_value_code_o, function_select_code_o, unit_enable_code_o}, {20'h0, rd_v, rs, 4'(e)});
      check({24'h0, decoded_unit_lines_n_o}, {24'h0, exp_lines(4'(e))});
      rd(GFVC_OFF_BUS_CMD, r);
      check(r, {20'h0, rd_v, rs, 4'(e)});
    end
    bus(4'h4, GFVC_SEL_ACTION, 4'h1);
    bus(4'hD, GFVC_SEL_ACTION, 4'h1);
    bus(4'h4, GFVC_SEL_RDBACK, 4'h0);
    wr(GFVC_OFF_STATUS, 32'hFFFF_FFFF);
    rd(GFVC_OFF_STATUS, r);
    check(r, 32'h0000_0001);
    rd(4'h1, r);
    check(r, 32'h0000_0000);
    sig_half = 8'(8 + $urandom % 8);
    bus(4'h5, GFVC_SEL_CONFIG, 4'h0);
    check({31'h0, clk_gate_from_volt_o}, 32'h0000_0000);
    {n_ref, n_sig, n_cc, n_yc} = '0;
    bus(4'h5, GFVC_SEL_ACTION, 4'h1);
    rd(GFVC_OFF_STATUS, r);
    check(r, 32'h0000_0002);
    sig_run = 1'b1;
    wait_on(1'b0, 1'b1, 60);
    repeat (17000) @(posedge clk_sys_i);
    sig_run = 1'b0;
    bus(4'h5, GFVC_SEL_ACTION, 4'h2);
    repeat (20) @(posedge clk_sys_i);
    rd(GFVC_OFF_STATUS, r);
    check(r, 32'h0000_0404);
    sig_run = 1'b1;
    wait_on(1'b0, 1'b0, 400);
    sig_run = 1'b0;
    rd(GFVC_OFF_STATUS, r);
    check(r, 32'h0000_0020);
    readout(1'b0);
    for (v = 0; v < 2; v++)
    begin
      stop_ticks = 16'(60 + $urandom % 400);
      bus(4'h5, GFVC_SEL_CONFIG, 4'h1);
      check({31'h0, clk_gate_from_volt_o}, 32'h0000_0001);
      {n_ref, n_cc, n_yc} = '0;
      bus(4'h5, GFVC_SEL_ACTION, 4'h4);
      check({31'h0, stop_gate_open_o}, 32'h0000_0000);
      wait_on(1'b1, 1'b1, 70);
      wait_on(1'b1, 1'b0, 4200);
      check({31'h0, stop_gate_open_o}, 32'h0000_0001);
      rd(GFVC_OFF_STATUS, r);
      check(r, 32'h0000_0A20);
      readout(1'b1);
    end
    test_done();
  end
endmodule // gfvc_top_bench
`default_nettype wire
